// [design/rcf_defines.svh]
// constants for the receive config and fault status block
// assumes inclusion by bare name from design files
`ifndef RCF_DEFINES_SVH
`define RCF_DEFINES_SVH
// register byte offsets
`define RCF_OFS_CFG      8'h00
`define RCF_OFS_STAT     8'h04
`define RCF_OFS_FRAMES   8'h08
// configuration word bit positions
`define RCF_B_RST        0
`define RCF_B_EN         1
`define RCF_B_VLAN       2
`define RCF_B_FCS        3
`define RCF_B_JUMBO      4
`define RCF_B_FC         5
`define RCF_B_PRE        7
`define RCF_B_LTDIS      8
`define RCF_B_CLDIS      9
`define RCF_B_INH        10
`define RCF_B_MTUEN      14
`define RCF_B_MTU_LO     16
`define RCF_B_MTU_HI     30
// writable bits, reserved ones stay zero
`define RCF_CFG_MASK     32'h7fff_47bf
`define RCF_CFG_RST_VAL  32'h0000_0000
// status bit positions
`define RCF_S_LF         0
`define RCF_S_RF         1
// frame lengths in bytes
`define RCF_LEN_MIN      16'h0040
`define RCF_LEN_STD      16'h05ee
`define RCF_LEN_VLAN     16'h05f2
// column encodings
`define RCF_SEQ_CHAR     8'h9c
`define RCF_SEQ_LF       8'h01
`define RCF_SEQ_RF       8'h02
`define RCF_IDLE_D       32'h0707_0707
`define RCF_IDLE_C       4'hf
`define RCF_SEQ_C        4'h1
`endif

// [design/rcf_pkg.sv]
// types shared by the receive config and fault status block
// assumes the defines header for widths of columns
package rcf_pkg;
    // kind of a received column
    typedef enum logic [1:0] {COL_DATA, COL_LF, COL_RF} rcf_col_e;
    // one frame descriptor from the receive pipeline
    typedef struct packed {
        logic [15:0] len;
        logic        is_ctrl;
        logic        is_pause;
        logic        is_vlan;
        logic        fcs_ok;
        logic        lt_err;
    } rcf_frame_s;
endpackage : rcf_pkg

// [design/rcf_frame_if.sv]
// carrier between the top and the frame judge
// assumes one clock domain, synchronous to clk
`timescale 1ns/100ps
interface rcf_frame_if;
    logic               done;      // frame descriptor strobe
    rcf_pkg::rcf_frame_s frm;      // descriptor
    logic [31:0]        cfg;       // live config word
    logic               good;      // frame delivered good
    logic               bad;       // frame delivered bad
    logic               drop;      // frame withheld from client
    logic               pause_req; // pause consumed
    logic               count;     // frame counted in statistics
    logic               keep_fcs;  // forward fcs bytes
    logic               keep_pre;  // forward preamble
    modport top   (output done, frm, cfg,
                   input good, bad, drop, pause_req, count, keep_fcs, keep_pre);
    modport judge (input done, frm, cfg,
                   output good, bad, drop, pause_req, count, keep_fcs, keep_pre);
endinterface : rcf_frame_if

// [design/rcf_frame_judge.sv]
// per-frame verdict from the receive configuration word
// assumes descriptors arrive one per done pulse in the clk domain
`timescale 1ns/100ps
`include "rcf_defines.svh"
module rcf_frame_judge (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    rcf_frame_if.judge fi
);
    ////////////////////////////////////////////////////////////////////
    // decode
    wire logic [15:0] mtu_w    = {1'b0, fi.cfg[`RCF_B_MTU_HI:`RCF_B_MTU_LO]};
    wire logic        en_w     = fi.cfg[`RCF_B_EN] & ~fi.cfg[`RCF_B_RST];
    // limit: mtu first, then jumbo, then vlan default
    wire logic [15:0] lim_w    = fi.cfg[`RCF_B_VLAN] && fi.frm.is_vlan
                                 ? `RCF_LEN_VLAN : `RCF_LEN_STD;
    wire logic        long_w   = fi.cfg[`RCF_B_MTUEN] ? (fi.frm.len > mtu_w)
                               : (!fi.cfg[`RCF_B_JUMBO] && fi.frm.len > lim_w);
    // control frames over minimum are bad unless check disabled
    wire logic        ctl_w    = fi.frm.is_ctrl && fi.frm.len > `RCF_LEN_MIN
                                 && !fi.cfg[`RCF_B_CLDIS];
    wire logic        lt_w     = fi.frm.lt_err && !fi.cfg[`RCF_B_LTDIS];
    // fcs always checked, even when stripped
    wire logic        bad_w    = !fi.frm.fcs_ok || lt_w || ctl_w || long_w;
    wire logic        pause_w  = fi.frm.is_pause && fi.cfg[`RCF_B_FC];
    wire logic        take_w   = fi.done && en_w;
    logic             good_reg;
    logic             bad_reg;
    logic             drop_reg;
    logic             pause_reg;
    logic             count_reg;
    ////////////////////////////////////////////////////////////////////
    // registered verdict, one cycle after done
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            good_reg  <= 1'b0;
            bad_reg   <= 1'b0;
            drop_reg  <= 1'b0;
            pause_reg <= 1'b0;
            count_reg <= 1'b0;
        end
        else if (ce)
        begin
            good_reg  <= take_w && !bad_w && !pause_w;
            bad_reg   <= take_w && bad_w && !pause_w;
            drop_reg  <= take_w && (pause_w || long_w);
            pause_reg <= take_w && pause_w && !bad_w;
            count_reg <= take_w && !(fi.frm.is_vlan && !fi.cfg[`RCF_B_VLAN]);
        end
    end
    assign fi.good      = good_reg;
    assign fi.bad       = bad_reg;
    assign fi.drop      = drop_reg;
    assign fi.pause_req = pause_reg;
    assign fi.count     = count_reg;
    assign fi.keep_fcs  = fi.cfg[`RCF_B_FCS];
    assign fi.keep_pre  = fi.cfg[`RCF_B_PRE];
    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_judge_fcs_bad: assert property (ce && take_w && !fi.frm.fcs_ok && !pause_w
        |=> bad_reg) else $error("bad fcs not flagged");
    a_judge_disabled: assert property (ce && !en_w |=> !good_reg && !bad_reg)
        else $error("verdict while disabled");
    a_judge_pause: assert property (ce && take_w && pause_w |=> drop_reg && !good_reg)
        else $error("pause frame reached client");
    a_judge_vlan_cnt: assert property (ce && take_w && fi.frm.is_vlan
        && !fi.cfg[`RCF_B_VLAN] |=> !count_reg) else $error("vlan frame counted");
    c_judge_good: cover property (good_reg);
    c_judge_pause: cover property (pause_reg);
endmodule : rcf_frame_judge

// [design/rcf_top.sv]
// receive configuration and link fault status, wishbone register port
// assumes all inputs synchronous to clk and a classic wishbone master
//
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`include "rcf_defines.svh"
module rcf_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // received column from the link
    input  wire logic [31:0] rx_col_d,
    input  wire logic [3:0]  rx_col_c,
    // client transmit column and link transmit column
    input  wire logic [31:0] tx_cli_d,
    input  wire logic [3:0]  tx_cli_c,
    output logic      [31:0] tx_col_d,
    output logic      [3:0]  tx_col_c,
    // frame descriptor from the receive pipeline
    input  wire logic        frm_done,
    input  wire logic [15:0] frm_len,
    input  wire logic        frm_is_ctrl,
    input  wire logic        frm_is_pause,
    input  wire logic        frm_is_vlan,
    input  wire logic        frm_fcs_ok,
    input  wire logic        frm_lt_err,
    // verdict to the client side
    output logic             frm_good,
    output logic             frm_bad,
    output logic             frm_drop,
    output logic             frm_count,
    output logic             keep_fcs,
    output logic             keep_pre,
    output logic             pause_req,
    output logic             rx_blk_rst,
    output logic             rx_active,
    output logic [1:0]       fault_status
);
    ////////////////////////////////////////////////////////////////////
    // column classification
    // one place for the ordered set match so rx and checks agree
    function automatic rcf_pkg::rcf_col_e col_kind(input logic [31:0] d,
                                                   input logic [3:0]  c);
        rcf_pkg::rcf_col_e k;
        k = rcf_pkg::COL_DATA;
        if (c == `RCF_SEQ_C && d[7:0] == `RCF_SEQ_CHAR && d[23:8] == 16'h0000)
        begin
            if (d[31:24] == `RCF_SEQ_LF)
                k = rcf_pkg::COL_LF;
            else if (d[31:24] == `RCF_SEQ_RF)
                k = rcf_pkg::COL_RF;
        end
        return k;
    endfunction : col_kind

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] cfg_reg;        // receive configuration word
    logic [31:0] cfg_next;       // after byte-lane merge
    logic [1:0]  stat_reg;       // fault status, read-only
    logic [31:0] frames_reg;     // counted frames
    logic        ack_reg;        // wishbone acknowledge
    logic [31:0] rdat_reg;       // read data
    logic [31:0] txd_reg;        // link transmit data
    logic [3:0]  txc_reg;        // link transmit control
    logic        blk_rst_reg;    // receive block reset

    ////////////////////////////////////////////////////////////////////
    // bus decode
    wire logic req_w     = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire logic wr_w      = req_w & wb_we_i;
    wire logic hit_cfg   = (wb_adr_i == `RCF_OFS_CFG);
    wire logic hit_stat  = (wb_adr_i == `RCF_OFS_STAT);
    wire logic hit_frm   = (wb_adr_i == `RCF_OFS_FRAMES);
    wire logic [31:0] lane_w = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // reserved bits never store, so they read back as zero
    assign cfg_next = ((cfg_reg & ~lane_w) | (wb_dat_i & lane_w))
                      & `RCF_CFG_MASK;
    // unmapped offsets read zero and still acknowledge
    wire logic [31:0] rsel_w = hit_cfg  ? cfg_reg
                             : hit_stat ? {30'h0000_0000, stat_reg}
                             : hit_frm  ? frames_reg
                             : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // fault detect
    wire rcf_pkg::rcf_col_e kind_w = col_kind(rx_col_d, rx_col_c);
    wire logic lf_w  = (kind_w == rcf_pkg::COL_LF);
    wire logic rf_w  = (kind_w == rcf_pkg::COL_RF);
    wire logic inh_w = cfg_reg[`RCF_B_INH];

    ////////////////////////////////////////////////////////////////////
    // link transmit select
    // local fault wins over remote fault, matching the link fault order
    wire logic [31:0] txd_w = inh_w ? tx_cli_d
                            : stat_reg[`RCF_S_LF] ? {`RCF_SEQ_RF, 16'h0000,
                                                     `RCF_SEQ_CHAR}
                            : stat_reg[`RCF_S_RF] ? `RCF_IDLE_D
                            : tx_cli_d;
    wire logic [3:0]  txc_w = inh_w ? tx_cli_c
                            : stat_reg[`RCF_S_LF] ? `RCF_SEQ_C
                            : stat_reg[`RCF_S_RF] ? `RCF_IDLE_C
                            : tx_cli_c;

    ////////////////////////////////////////////////////////////////////
    // wishbone handshake, answer one cycle after the request
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end
        else if (ce)
        begin
            ack_reg  <= req_w;
            rdat_reg <= req_w ? rsel_w : rdat_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration word, all in the clk domain
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cfg_reg <= `RCF_CFG_RST_VAL;
        else if (ce && wr_w && hit_cfg)
            cfg_reg <= cfg_next;
    end

    ////////////////////////////////////////////////////////////////////
    // fault status follows the column every cycle that ce is high
    // no latching: software sees the live condition, so a short fault may be missed
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            stat_reg <= 2'b00;
        else if (ce)
        begin
            stat_reg[`RCF_S_LF] <= lf_w;
            stat_reg[`RCF_S_RF] <= rf_w;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link transmit column register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            txd_reg <= `RCF_IDLE_D;
            txc_reg <= `RCF_IDLE_C;
        end
        else if (ce)
        begin
            txd_reg <= txd_w;
            txc_reg <= txc_w;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive block reset: port reset or the config bit
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            blk_rst_reg <= 1'b1;
        else if (ce)
            blk_rst_reg <= cfg_reg[`RCF_B_RST];
    end

    ////////////////////////////////////////////////////////////////////
    // frame judge
    rcf_frame_if fi ();
    assign fi.done = frm_done;
    assign fi.frm  = '{len: frm_len, is_ctrl: frm_is_ctrl, is_pause: frm_is_pause,
                       is_vlan: frm_is_vlan, fcs_ok: frm_fcs_ok, lt_err: frm_lt_err};
    assign fi.cfg  = cfg_reg;

    rcf_frame_judge u_judge (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .fi  (fi.judge)
    );

    ////////////////////////////////////////////////////////////////////
    // statistics counter, wraps; writes are ignored
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            frames_reg <= 32'h0000_0000;
        else if (ce && fi.count)
            frames_reg <= frames_reg + 32'h0000_0001;
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign wb_ack_o     = ack_reg;
    assign wb_dat_o     = rdat_reg;
    assign tx_col_d     = txd_reg;
    assign tx_col_c     = txc_reg;
    assign frm_good     = fi.good;
    assign frm_bad      = fi.bad;
    assign frm_drop     = fi.drop;
    assign frm_count    = fi.count;
    assign keep_fcs     = fi.keep_fcs;
    assign keep_pre     = fi.keep_pre;
    assign pause_req    = fi.pause_req;
    assign rx_blk_rst   = blk_rst_reg | rst;
    assign rx_active    = cfg_reg[`RCF_B_EN] & ~blk_rst_reg;
    assign fault_status = stat_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_fault_local: assert property (ce && lf_w |=> fault_status[0])
        else $error("local fault bit not set");
    a_fault_remote: assert property (ce && rf_w |=> fault_status[1])
        else $error("remote fault bit not set");
    a_fault_clear: assert property (ce && !lf_w && !rf_w |=> fault_status == 2'b00)
        else $error("fault bit stuck");
    a_tx_remote: assert property (ce && !inh_w && stat_reg[0]
        |=> tx_col_c == 4'h1 && tx_col_d[31:24] == 8'h02)
        else $error("no remote fault sent");
    a_tx_idle: assert property (ce && !inh_w && stat_reg == 2'b10
        |=> tx_col_d == 32'h0707_0707 && tx_col_c == 4'hf)
        else $error("no idle on remote fault");
    a_tx_inhibit: assert property (ce && inh_w
        |=> tx_col_d == $past(tx_cli_d) && tx_col_c == $past(tx_cli_c))
        else $error("inhibit did not pass data");
    a_cfg_reserved: assert property (cfg_reg[6] == 1'b0 && cfg_reg[15] == 1'b0)
        else $error("reserved bit stored");
    a_wb_ack: assert property (ce && req_w |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not single cycle");
    a_blk_reset: assert property (ce && cfg_reg[0] |=> rx_blk_rst && !rx_active)
        else $error("receive reset not held");

    c_local_fault: cover property (lf_w ##1 fault_status[0]);
    c_remote_fault: cover property (rf_w ##1 fault_status[1]);
    c_cfg_write: cover property (wr_w && hit_cfg);
    c_inhibit: cover property (inh_w && stat_reg != 2'b00);
endmodule : rcf_top

// [verif/rcf_link_model.sv]
// link-side column source for the receive fault bench
// assumes the block's clk; mode is held steady by the bench
`timescale 1ns/100ps
`include "rcf_defines.svh"
module rcf_link_model (
    input  wire logic        clk,
    input  wire logic [1:0]  mode,
    output logic      [31:0] col_d,
    output logic      [3:0]  col_c
);
    logic [31:0] pat_reg; // data pattern, moves every cycle so no stale value hides

    initial
    begin
        pat_reg = 32'h0000_0000;
        col_d   = `RCF_IDLE_D;
        col_c   = `RCF_IDLE_C;
    end

    // columns change right after the edge, in the receive clock domain
    always @(posedge clk)
    begin
        pat_reg <= pat_reg + 32'h0001_0203;
        if (mode == 2'h1)
        begin
            col_d <= {`RCF_SEQ_LF, 16'h0000, `RCF_SEQ_CHAR}; // local fault set
            col_c <= `RCF_SEQ_C;
        end
        else if (mode == 2'h2)
        begin
            col_d <= {`RCF_SEQ_RF, 16'h0000, `RCF_SEQ_CHAR}; // remote fault set
            col_c <= `RCF_SEQ_C;
        end
        else
        begin
            col_d <= pat_reg; // plain data, no control lanes
            col_c <= 4'h0;
        end
    end
endmodule : rcf_link_model

// [verif/tb_top.sv]
// self-checking bench for the receive config and fault status block
// assumes the design files and the link model are compiled first
`timescale 1ns/100ps
`include "rcf_defines.svh"
module tb_top;
    logic clk, rst, ce, cyc, stb, we, ack, done, good, bad, drop, cnt, kfcs, kpre, preq;
    logic        blk_rst, active;
    logic [7:0]  adr;
    logic [3:0]  sel, rxc, txc;
    logic [31:0] wdat, rdat, rxd, txd, rd;
    logic [31:0] cli;     // client column, changed per fault case so stale data shows
    logic [15:0] len;
    logic [4:0]  flg;     // ctrl, pause, vlan, fcs ok, lt err
    logic [1:0]  fst, mode;
    int          num_errors, n_checks, exp_frames;
    // row: cfg word, length, flags, expected {good, bad, drop, count, pause}
    localparam logic [57:0] ROWS [19] = '{
        {32'h0000_0002, 16'h05ee, 5'h02, 5'h12},
        {32'h0000_0002, 16'h05ef, 5'h02, 5'h0e},
        {32'h0000_0006, 16'h05f2, 5'h06, 5'h12},
        {32'h0000_0006, 16'h05f3, 5'h06, 5'h0e},
        {32'h0000_0002, 16'h05ee, 5'h06, 5'h10},
        {32'h0000_0012, 16'h2328, 5'h02, 5'h12},
        {32'h0000_000a, 16'h0040, 5'h00, 5'h0a},
        {32'h0000_0082, 16'h0040, 5'h02, 5'h12},
        {32'h0000_0002, 16'h0040, 5'h03, 5'h0a},
        {32'h0000_0102, 16'h0040, 5'h03, 5'h12},
        {32'h0000_0002, 16'h0041, 5'h12, 5'h0a},
        {32'h0000_0202, 16'h0041, 5'h12, 5'h12},
        {32'h0000_0002, 16'h0040, 5'h12, 5'h12},
        {32'h0000_0022, 16'h0040, 5'h1a, 5'h07},   // pfc never set
        {32'h0000_0002, 16'h0040, 5'h1a, 5'h12},
        {32'h0064_4002, 16'h0065, 5'h02, 5'h0e},
        {32'h0064_4002, 16'h0064, 5'h02, 5'h12},
        {32'h0000_0000, 16'h0040, 5'h02, 5'h00},
        {32'h0000_0003, 16'h0040, 5'h02, 5'h00}};

    rcf_link_model link (.clk(clk), .mode(mode), .col_d(rxd), .col_c(rxc));

    rcf_top dut (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rx_col_d(rxd), .rx_col_c(rxc), .tx_cli_d(cli), .tx_cli_c(4'h0),
        .tx_col_d(txd), .tx_col_c(txc), .frm_done(done), .frm_len(len),
        .frm_is_ctrl(flg[4]), .frm_is_pause(flg[3]), .frm_is_vlan(flg[2]),
        .frm_fcs_ok(flg[1]), .frm_lt_err(flg[0]), .frm_good(good), .frm_bad(bad),
        .frm_drop(drop), .frm_count(cnt), .keep_fcs(kfcs), .keep_pre(kpre),
        .pause_req(preq), .rx_blk_rst(blk_rst), .rx_active(active), .fault_status(fst));

    ////////////////////////////////////////////////////////////////////////////////
    // clock, 4 ns period
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // one comparison, counted
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // classic single cycle; waits for ack, no fixed latency assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        chk("wb_ack", 32'h1, 32'(ack));
        rd = rdat; // taken at the acked edge only
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk);
    endtask : wb

    // verdict pulses stand one cycle after the descriptor
    task automatic frame(input logic [57:0] r);
        @(posedge clk);
        done <= 1'b1; len <= r[25:10]; flg <= r[9:5];
        @(posedge clk);
        done <= 1'b0;
        #1;
        chk("verdict", 32'(r[4:0]), 32'({good, bad, drop, cnt, preq}));
    endtask : frame

    // summary, verdict, end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    // watchdog: the whole run needs well under 3000 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        num_errors = 0; n_checks = 0; exp_frames = 0;
        rst = 1'b1; ce = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
        sel = 4'h0; wdat = 32'h0; done = 1'b0; len = 16'h0; flg = 5'h0; mode = 2'h0;
        cli = 32'h5a5a_a5a5;
        repeat (4) @(posedge clk);
        #1;
        chk("reset tx", {`RCF_IDLE_D}, txd);
        chk("reset out", 32'h8, 32'({blk_rst, active, fst}));
        @(posedge clk);
        rst <= 1'b0;
        // ordinary frame cases, table driven
        foreach (ROWS[i])
        begin
            wb(1'b1, `RCF_OFS_CFG, ROWS[i][57:26]); // reserved bits zero
            chk("levels", 32'({ROWS[i][26], ROWS[i][27] & ~ROWS[i][26], ROWS[i][33],
                ROWS[i][29]}), 32'({blk_rst, active, kpre, kfcs}));
            frame(ROWS[i]);
            exp_frames += int'(ROWS[i][1]);
        end
        $display("test frames done");
        wb(1'b0, `RCF_OFS_FRAMES, 32'h0);
        chk("frames", 32'(exp_frames), rd);
        // fault sets with inhibit off and on; order shows bits falling again
        for (int inh = 0; inh < 2; inh++)
            for (int m = 1; m < 4; m++)
            begin
                wb(1'b1, `RCF_OFS_CFG, {21'h0, inh[0], 10'h002});
                mode <= m[1:0];
                cli  <= 32'h5a5a_a500 | 32'(m);
                repeat (4) @(posedge clk);
                #1;
                chk("status", 32'(m % 3), 32'(fst));
                chk("tx_d", (inh == 1 || m == 3) ? (32'h5a5a_a500 | 32'(m)) : (m == 1) ?
                    {`RCF_SEQ_RF, 16'h0, `RCF_SEQ_CHAR} : `RCF_IDLE_D, txd);
                chk("tx_c", (inh == 1 || m == 3) ? 32'h0 : (m == 1) ? 32'(`RCF_SEQ_C) :
                    32'(`RCF_IDLE_C), 32'(txc));
                wb(1'b1, `RCF_OFS_STAT, 32'h0000_0000);
                wb(1'b0, `RCF_OFS_STAT, 32'h0);
                chk("status reg", 32'(m % 3), rd);
            end
        // clock enable low freezes the status even though the link shows a fault
        mode <= 2'h1;
        ce   <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("frozen status", 32'h0, 32'(fst));
        @(posedge clk);
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("thawed status", 32'h1, 32'(fst));
        @(posedge clk);
        mode <= 2'h0;
        $display("test faults done");
        // register map corners
        wb(1'b1, `RCF_OFS_CFG, `RCF_CFG_MASK);
        wb(1'b0, `RCF_OFS_CFG, 32'h0);
        chk("cfg readback", `RCF_CFG_MASK, rd);
        wb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 32'h0, rd);
        // reset in mid-run clears the word and holds the receiver
        @(posedge clk);
        rst <= 1'b1;
        #1;
        chk("mid reset", 32'h8, 32'({blk_rst, active, fst}));
        @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, `RCF_OFS_CFG, 32'h0);
        chk("cfg after reset", `RCF_CFG_RST_VAL, rd);
        $display("test registers done");
        close_out();
    end
endmodule : tb_top
